// ===== verilog/emm_pkg.sv
// Constants and types shared by the Ethernet mode control block
package emm_pkg;

  // Register byte addresses on the AHB-Lite bus
  localparam logic [31:0] MODE_ADDR = 32'h3000_3400;
  localparam logic [31:0] STATUS_ADDR = 32'h3000_3480;

  // Value after reset: accept_any_frame set, all else clear
  localparam logic [31:0] MODE_RESET = 32'h0004_0000;
  // Writable bits of the control word, reserved ones clear
  localparam logic [31:0] MODE_WRITE_MASK = 32'hD8FF_BDEC;

  // AHB encodings used by the slave
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // Medium timing: 10 Mb/s bit time, link clock carries one nibble
  localparam int BIT_TIME_NS = 100;
  localparam int LINK_PERIOD_NS = 400;
  localparam int BITS_PER_EDGE = LINK_PERIOD_NS / BIT_TIME_NS;
  localparam int SLOT_BITS = 512;
  localparam int SLOT_EDGES = SLOT_BITS / BITS_PER_EDGE;
  localparam logic [6:0] SLOT_LAST = 7'(SLOT_EDGES - 1);
  localparam int DEFER_LIMIT_BITS = 24288;
  localparam int DEFER_LIMIT_EDGES = DEFER_LIMIT_BITS / BITS_PER_EDGE;

  // Collision policy and pad strip figures
  localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
  localparam logic [4:0] K_LIMIT = 5'h0A;
  localparam logic [15:0] PAD_MIN_LENGTH = 16'h002E;
  localparam logic [19:0] LFSR_SEED = 20'h00001;

  // Control word laid out bit for bit, bit 31 first
  typedef struct packed {
    logic receive_everything;
    logic buffer_byte_order;
    logic rsv29;
    logic heartbeat_off;
    logic port_choice;
    logic [2:0] rsv26_24;
    logic block_own_receive;
    logic [1:0] loopback_select;
    logic full_duplex_on;
    logic accept_all_group;
    logic accept_any_frame;
    logic inverse_filter;
    logic keep_bad_frames;
    logic hash_for_unicast;
    logic rsv14;
    logic hash_or_perfect;
    logic late_collision_retry;
    logic drop_broadcast;
    logic single_attempt;
    logic rsv9;
    logic auto_pad_strip;
    logic [1:0] backoff_bits_cap;
    logic deferral_limit_on;
    logic rsv4;
    logic transmitter_on;
    logic receiver_on;
    logic [1:0] rsv1_0;
  } emm_mode_type;

  // Loopback selections
  localparam logic [1:0] LOOP_NORMAL = 2'h0;
  localparam logic [1:0] LOOP_INTERNAL = 2'h1;
  localparam logic [1:0] LOOP_EXTERNAL = 2'h2;

  // Header of a received frame, offered once at its end
  typedef struct packed {
    logic [47:0] dest_addr;
    logic [5:0] hash_index;
    logic bad;
    logic [15:0] length_field;
  } emm_rx_info_type;

  // One nibble of media data
  typedef struct packed {
    logic en;
    logic [3:0] data;
  } emm_nibble_type;

endpackage

// ===== verilog/emm_mode_control.sv
// Mode control: register, address filter, port routing, collision policy
`timescale 1ns/1ps
`default_nettype none

module emm_mode_control #(
  parameter int DEFER_LIMIT = emm_pkg::DEFER_LIMIT_EDGES
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Control word as seen by the MAC core
  output emm_pkg::emm_mode_type mode_out,
  // Other address-check state supplied by its own registers
  input wire logic [47:0] station_addr_in,
  input wire logic [63:0] hash_table_in,
  // Receive frame decision
  input wire logic rx_frame_end_in,
  input wire emm_pkg::emm_rx_info_type rx_info_in,
  output logic rx_deliver_out,
  output logic rx_strip_out,
  // Buffer word byte order
  input wire logic [31:0] buf_word_in,
  output logic [31:0] buf_word_out,
  // Nibble streams: core side and the two media ports
  input wire emm_pkg::emm_nibble_type core_tx_in,
  output emm_pkg::emm_nibble_type core_rx_out,
  output emm_pkg::emm_nibble_type mii_tx_out,
  input wire emm_pkg::emm_nibble_type mii_rx_in,
  output emm_pkg::emm_nibble_type serial_tx_out,
  input wire emm_pkg::emm_nibble_type serial_rx_in,
  output logic external_loop_out,
  // Heartbeat check
  input wire logic sqe_missing_in,
  output logic sqe_check_on_out,
  output logic heartbeat_fail_out,
  // Transmit attempt control
  input wire logic link_clock_in,
  input wire logic tx_request_in,
  input wire logic carrier_sense_in,
  input wire logic collision_in,
  input wire logic late_collision_in,
  input wire logic tx_done_in,
  output logic tx_go_out,
  output logic tx_drop_out,
  output logic retry_error_out,
  output logic late_collision_out,
  output logic defer_abort_out
);

  // Transmit attempt states
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_DEFER = 4'b0010,
    TX_SEND = 4'b0100,
    TX_BACKOFF = 4'b1000
  } emm_tx_state_type;

  // Byte reversal of a buffer word
  function automatic logic [31:0] swap_bytes(input logic [31:0] w);
    swap_bytes = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  // Mask of the low LFSR bits used for the wait count
  function automatic logic [9:0] wait_mask(input logic [4:0] k,
                                           input logic [1:0] cap);
    logic [4:0] limit;
    logic [4:0] bits;
    limit = 5'h0A;
    unique case (cap)
      2'h0: limit = 5'h0A;
      2'h1: limit = 5'h08;
      2'h2: limit = 5'h04;
      2'h3: limit = 5'h01;
    endcase
    bits = (k < limit) ? k : limit;
    wait_mask = 10'((11'h001 << bits) - 11'h001);
  endfunction

  // Reset release through two flip-flops
  logic rst_meta;
  logic rst_b;
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_b <= rst_meta;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b);

  // ---------------- AHB-Lite slave ----------------
  emm_pkg::emm_mode_type mode; // Control word
  logic wr_pend; // Write data phase for the control word pending
  logic take; // Valid word transfer in address phase
  logic [31:0] status_word; // Read view of internal state

  assign take = hsel_in && htrans_in[1] && hready_in
                && (hsize_in == emm_pkg::HSIZE_WORD);
  // Zero wait states; every answer is OKAY, unmapped reads give zero
  assign hreadyout_out = 1'b1;
  assign hresp_out = emm_pkg::HRESP_OKAY;
  assign mode_out = mode;

  // Remember a write to the control word for its data phase
  always_ff @(posedge clock_in or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend <= 1'b0;
    end else if (hready_in) begin
      wr_pend <= take && hwrite_in && (haddr_in == emm_pkg::MODE_ADDR);
    end
  end

  // Control word update; reserved bits stay clear
  always_ff @(posedge clock_in or negedge rst_b) begin
    if (!rst_b) begin
      mode <= emm_pkg::MODE_RESET;
    end else if (wr_pend) begin
      mode <= hwdata_in & emm_pkg::MODE_WRITE_MASK;
    end
  end

  // Read data is prepared in the address phase so it is a flip-flop
  always_ff @(posedge clock_in or negedge rst_b) begin
    if (!rst_b) begin
      hrdata_out <= 32'h0000_0000;
    end else if (take && !hwrite_in) begin
      if (haddr_in == emm_pkg::MODE_ADDR) begin
        hrdata_out <= mode & emm_pkg::MODE_WRITE_MASK;
      end else if (haddr_in == emm_pkg::STATUS_ADDR) begin
        hrdata_out <= status_word;
      end else begin
        hrdata_out <= 32'h0000_0000;
      end
    end
  end

  a_reserved_zero: assert property (
    (mode & ~emm_pkg::MODE_WRITE_MASK) == 32'h0000_0000)
    else $error("reserved control bit became set");

  // ---------------- Buffer byte order ----------------
  // Only buffer words are swapped; registers are unaffected
  always_ff @(posedge clock_in or negedge rst_b) begin
    if (!rst_b) begin
      buf_word_out <= 32'h0000_0000;
    end else if (mode.buffer_byte_order) begin
      buf_word_out <= swap_bytes(buf_word_in);
    end else begin
      buf_word_out <= buf_word_in;
    end
  end

  a_byte_swap: assert property (
    mode.buffer_byte_order |=>
      buf_word_out == swap_bytes($past(buf_word_in)))
    else $error("buffer word not byte swapped");

  // ---------------- Port routing and loopback ----------------
  logic internal_loop; // Internal turnaround in effect
  logic tx_allowed; // Transmit gate
  emm_pkg::emm_nibble_type rx_pick; // Selected receive source
  logic own_block; // Receive blocked by own transmission

  // Internal loopback is refused in full duplex
  assign internal_loop = (mode.loopback_select == emm_pkg::LOOP_INTERNAL)
                         && !mode.full_duplex_on;
  assign tx_allowed = mode.transmitter_on;
  assign own_block = mode.block_own_receive && core_tx_in.en
                     && !internal_loop;

  // Pick the receive source by loopback and port choice
  always_comb begin
    if (internal_loop) begin
      rx_pick = core_tx_in;
    end else if (mode.port_choice) begin
      rx_pick = serial_rx_in;
    end else begin
      rx_pick = mii_rx_in;
    end
  end

  // Media outputs and receive data, all registered
  always_ff @(posedge clock_in or negedge rst_b) begin
    if (!rst_b) begin
      mii_tx_out <= '0;
      serial_tx_out <= '0;
      core_rx_out <= '0;
      external_loop_out <= 1'b0;
    end else begin
      // Internal loopback keeps frames off the media
      mii_tx_out.en <= core_tx_in.en && tx_allowed && !mode.port_choice
                       && !internal_loop;
      mii_tx_out.data <= core_tx_in.data;
      serial_tx_out.en <= core_tx_in.en && tx_allowed && mode.port_choice
                          && !internal_loop;
      serial_tx_out.data <= core_tx_in.data;
      core_rx_out.en <= rx_pick.en && mode.receiver_on && !own_block;
      core_rx_out.data <= rx_pick.data;
      // External loop asks the PHY to turn frames round, full duplex only
      external_loop_out <= (mode.loopback_select == emm_pkg::LOOP_EXTERNAL)
                           && mode.full_duplex_on;
    end
  end

  a_tx_gate_off: assert property (
    !mode.transmitter_on |=> !mii_tx_out.en && !serial_tx_out.en)
    else $error("transmit while transmitter off");
  a_rx_gate_off: assert property (
    !mode.receiver_on |=> !core_rx_out.en)
    else $error("receive while receiver off");
  a_own_block: assert property (
    mode.block_own_receive && core_tx_in.en && !internal_loop
      |=> !core_rx_out.en)
    else $error("own frame received");
  a_port_route: assert property (
    mode.port_choice && core_tx_in.en && mode.transmitter_on
      && !internal_loop |=> serial_tx_out.en && !mii_tx_out.en)
    else $error("serial port not selected");

  // ---------------- Heartbeat check ----------------
  // Full duplex has no SQE to look for
  always_ff @(posedge clock_in or negedge rst_b) begin
    if (!rst_b) begin
      sqe_check_on_out <= 1'b0;
      heartbeat_fail_out <= 1'b0;
    end else begin
      sqe_check_on_out <= !mode.heartbeat_off
                          && !mode.full_duplex_on;
      heartbeat_fail_out <= sqe_missing_in && !mode.heartbeat_off
                            && !mode.full_duplex_on;
    end
  end

  // ---------------- Receive address filter ----------------
  logic is_group; // First destination bit on the wire
  logic is_bcast; // All-ones destination
  logic hash_hit; // Table bit selected by CRC index
  logic perfect_hit; // Station match, optionally inverted
  logic pass_addr; // Address filter result

  assign is_group = rx_info_in.dest_addr[40];
  assign is_bcast = &rx_info_in.dest_addr;
  // Top index bit picks the word, low five the bit
  assign hash_hit = hash_table_in[rx_info_in.hash_index];
  assign perfect_hit = (rx_info_in.dest_addr == station_addr_in)
                       ^ mode.inverse_filter;

  // Decision order: receive-all, promiscuous, broadcast, group, unicast
  always_comb begin
    if (mode.receive_everything) begin
      pass_addr = 1'b1;
    end else if (mode.accept_any_frame) begin
      pass_addr = 1'b1;
    end else if (is_bcast) begin
      pass_addr = !mode.drop_broadcast;
    end else if (is_group) begin
      if (mode.accept_all_group) begin
        pass_addr = 1'b1;
      end else if (mode.hash_or_perfect) begin
        pass_addr = hash_hit;
      end else begin
        pass_addr = perfect_hit;
      end
    end else if (mode.hash_or_perfect && mode.hash_for_unicast) begin
      pass_addr = hash_hit;
    end else begin
      pass_addr = perfect_hit;
    end
  end

  // Deliver decision and pad strip flag, one pulse per frame end
  always_ff @(posedge clock_in or negedge rst_b) begin
    if (!rst_b) begin
      rx_deliver_out <= 1'b0;
      rx_strip_out <= 1'b0;
    end else begin
      rx_deliver_out <= rx_frame_end_in && mode.receiver_on && pass_addr
                        && (!rx_info_in.bad || mode.keep_bad_frames);
      rx_strip_out <= rx_frame_end_in && mode.auto_pad_strip
                      && (rx_info_in.length_field
                          < emm_pkg::PAD_MIN_LENGTH);
    end
  end

  a_accept_all: assert property (
    rx_frame_end_in && mode.receiver_on && mode.receive_everything
      && !rx_info_in.bad |=> rx_deliver_out)
    else $error("receive-all frame not delivered");
  a_drop_bcast: assert property (
    rx_frame_end_in && is_bcast && mode.drop_broadcast
      && !mode.receive_everything && !mode.accept_any_frame
      |=> !rx_deliver_out)
    else $error("broadcast delivered while dropped");
  a_pad_strip: assert property (
    rx_strip_out |-> $past(mode.auto_pad_strip)
      && $past(rx_info_in.length_field) < emm_pkg::PAD_MIN_LENGTH)
    else $error("strip flagged for long frame");

  // ---------------- Link clock edges ----------------
  logic [2:0] link_sync; // Three-stage sampler
  logic link_level; // Accepted level
  logic link_rise; // One cycle per accepted rising edge

  // Stage 0 feeds only stage 1; stages 1 and 2 must agree
  always_ff @(posedge clock_in or negedge rst_b) begin
    if (!rst_b) begin
      link_sync <= 3'h0;
      link_level <= 1'b0;
    end else begin
      link_sync <= {link_sync[1:0], link_clock_in};
      if (link_sync[1] == link_sync[2]) begin
        link_level <= link_sync[2];
      end
    end
  end
  assign link_rise = (link_sync[1] == link_sync[2]) && link_sync[2]
                     && !link_level;

  // ---------------- Random source ----------------
  logic [19:0] lfsr; // Free-running 20-bit LFSR

  always_ff @(posedge clock_in or negedge rst_b) begin
    if (!rst_b) begin
      lfsr <= emm_pkg::LFSR_SEED;
    end else begin
      lfsr <= {lfsr[18:0], lfsr[19] ^ lfsr[16]};
    end
  end

  // ---------------- Transmit attempt control ----------------
  emm_tx_state_type state;
  logic [4:0] collisions; // Collisions so far on this frame
  logic [9:0] wait_slots; // Slots still to wait
  logic [6:0] slot_edges; // Link edges within the current slot
  logic [15:0] defer_edges; // Link edges spent deferring
  logic [4:0] next_k; // K for the coming back-off
  logic coll_stop; // Collision ends this frame
  logic late_drop; // Late collision not retried

  assign next_k = ((collisions + 5'h01) < emm_pkg::K_LIMIT)
                  ? (collisions + 5'h01) : emm_pkg::K_LIMIT;
  assign late_drop = late_collision_in && !mode.late_collision_retry;
  assign coll_stop = mode.single_attempt
                     || (collisions == emm_pkg::MAX_ATTEMPTS - 5'h01);
  assign tx_go_out = (state == TX_SEND) && mode.transmitter_on;

  // Attempt sequencing and event pulses
  always_ff @(posedge clock_in or negedge rst_b) begin
    if (!rst_b) begin
      state <= TX_IDLE;
      collisions <= 5'h00;
      wait_slots <= 10'h000;
      tx_drop_out <= 1'b0;
      retry_error_out <= 1'b0;
      late_collision_out <= 1'b0;
      defer_abort_out <= 1'b0;
    end else begin
      tx_drop_out <= 1'b0;
      retry_error_out <= 1'b0;
      late_collision_out <= 1'b0;
      defer_abort_out <= 1'b0;
      unique case (state)
        TX_IDLE: begin
          collisions <= 5'h00;
          if (tx_request_in && mode.transmitter_on) begin
            state <= TX_DEFER;
          end
        end
        TX_DEFER: begin
          if (mode.deferral_limit_on && carrier_sense_in
              && defer_edges > 16'(DEFER_LIMIT)) begin
            defer_abort_out <= 1'b1;
            state <= TX_IDLE;
          end else if (!carrier_sense_in) begin
            state <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (collision_in) begin
            late_collision_out <= late_collision_in;
            if (late_drop) begin
              tx_drop_out <= 1'b1;
              state <= TX_IDLE;
            end else if (coll_stop) begin
              retry_error_out <= 1'b1;
              tx_drop_out <= 1'b1;
              state <= TX_IDLE;
            end else begin
              collisions <= collisions + 5'h01;
              wait_slots <= lfsr[9:0]
                & wait_mask(next_k, mode.backoff_bits_cap);
              state <= TX_BACKOFF;
            end
          end else if (tx_done_in) begin
            state <= TX_IDLE;
          end
        end
        TX_BACKOFF: begin
          if (wait_slots == 10'h000) begin
            state <= TX_DEFER;
          end else if (link_rise && slot_edges == emm_pkg::SLOT_LAST) begin
            wait_slots <= wait_slots - 10'h001;
          end
        end
      endcase
    end
  end

  // Slot timer runs only while backing off
  always_ff @(posedge clock_in or negedge rst_b) begin
    if (!rst_b) begin
      slot_edges <= 7'h00;
    end else if (state != TX_BACKOFF) begin
      slot_edges <= 7'h00;
    end else if (link_rise) begin
      slot_edges <= slot_edges + 7'h01;
    end
  end

  // Deferral timer restarts at each new deferral, saturates at the top
  always_ff @(posedge clock_in or negedge rst_b) begin
    if (!rst_b) begin
      defer_edges <= 16'h0000;
    end else if (state != TX_DEFER) begin
      defer_edges <= 16'h0000;
    end else if (link_rise && carrier_sense_in && !(&defer_edges)) begin
      defer_edges <= defer_edges + 16'h0001;
    end
  end

  // Upper 17 bits read zero so the fields sit at [14:0]
  assign status_word = {17'h0_0000, state, 1'b0, link_level, collisions,
                        wait_slots[3:0]};

  a_retry_once: assert property (
    state == TX_SEND && collision_in && !late_collision_in
      && mode.single_attempt |=> retry_error_out && state == TX_IDLE)
    else $error("single attempt did not end frame");
  a_backoff_cap: assert property (
    state == TX_BACKOFF && $past(state) == TX_SEND
      |-> (wait_slots & ~wait_mask(collisions,
                                   $past(mode.backoff_bits_cap))) == 10'h000)
    else $error("backoff wait exceeds bit cap");
  a_late_report: assert property (
    state == TX_SEND && collision_in && late_collision_in
      |=> late_collision_out
        && tx_drop_out == (!$past(mode.late_collision_retry)
                           || $past(coll_stop)))
    else $error("late collision not handled");
  a_defer_abort: assert property (
    defer_abort_out |-> $past(mode.deferral_limit_on)
      && $past(defer_edges) > 16'(DEFER_LIMIT))
    else $error("deferral abort without limit");

endmodule // emm_mode_control

`default_nettype wire

// ===== verif/emm_phy_model.sv
// PHY model: free-running link clock and MII receive stream
`timescale 1ns/1ps
`default_nettype none
module emm_phy_model (
  input wire logic clock_in,
  input wire logic loop_in,
  input wire emm_pkg::emm_nibble_type tx_in,
  output var logic link_clock_out,
  output emm_pkg::emm_nibble_type rx_out
);
  logic [3:0] idle_nib = 4'h0; // Changing idle data
  emm_pkg::emm_nibble_type rx_reg = '0; // Registered receive nibble
  // MII clocks run free; offset keeps phase unrelated to the system clock
  initial begin
    link_clock_out = 1'b0;
    #137;
    forever #200 link_clock_out = ~link_clock_out;
  end
  // External loop turns frames back, else idle with changing data
  always @(posedge clock_in) begin
    idle_nib <= ~idle_nib;
    rx_reg <= loop_in ? tx_in : {1'b0, idle_nib};
  end
  assign rx_out = rx_reg;
endmodule // emm_phy_model
`default_nettype wire

// ===== verif/emm_mode_control_tb.sv
// Self-checking bench for the Ethernet mode control block
`timescale 1ns/1ps
`default_nettype none
module emm_mode_control_tb;
  logic clock_in = 1'b0, rst_b_in = 1'b0, hsel_in = 1'b0, hwrite_in = 1'b0;
  logic [31:0] haddr_in = '0, hwdata_in = '0, buf_word_in = '0;
  logic [31:0] hrdata_out, buf_word_out, q, rnd = 32'hDDF70B7B;
  logic [1:0] htrans_in = '0;
  logic [2:0] hsize_in = '0;
  logic [47:0] station_addr_in = '0, dst;
  logic [63:0] hash_table_in = '0;
  logic hreadyout_out, hresp_out, rx_frame_end_in = 1'b0, rx_deliver_out;
  logic rx_strip_out, external_loop_out, sqe_missing_in = 1'b0, e;
  logic sqe_check_on_out, heartbeat_fail_out, link_clock_in, tx_go_out;
  logic tx_request_in = 1'b0, carrier_sense_in = 1'b0, collision_in = 1'b0;
  logic late_collision_in = 1'b0, tx_done_in = 1'b0, tx_drop_out;
  logic retry_error_out, late_collision_out, defer_abort_out;
  emm_pkg::emm_mode_type mode_out;
  emm_pkg::emm_rx_info_type rx_info_in = '0;
  emm_pkg::emm_nibble_type core_tx_in = '0, core_rx_out, mii_tx_out;
  emm_pkg::emm_nibble_type mii_rx_in, serial_tx_out, serial_rx_in = '0;
  // Frame filter cases: mode word and address kind (0 other, 1 own, 2 bcast)
  emm_pkg::emm_mode_type md[7] = '{32'h00040000, 32'h00040104, 32'h4,
    32'h4, 32'h80000104, 32'h00000804, 32'h4};
  int kd[7] = '{0, 0, 0, 1, 0, 2, 2};
  int fail_count = 0, checks = 0, n;
  emm_mode_control #(.DEFER_LIMIT(20)) dut (.clock_in, .rst_b_in, .hsel_in,
    .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hwdata_in,
    .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out, .hresp_out,
    .mode_out, .station_addr_in, .hash_table_in, .rx_frame_end_in,
    .rx_info_in, .rx_deliver_out, .rx_strip_out, .buf_word_in,
    .buf_word_out, .core_tx_in, .core_rx_out, .mii_tx_out, .mii_rx_in,
    .serial_tx_out, .serial_rx_in, .external_loop_out, .sqe_missing_in,
    .sqe_check_on_out, .heartbeat_fail_out, .link_clock_in,
    .tx_request_in, .carrier_sense_in, .collision_in, .late_collision_in,
    .tx_done_in, .tx_go_out, .tx_drop_out, .retry_error_out,
    .late_collision_out, .defer_abort_out);
  emm_phy_model phy (.clock_in, .loop_in(external_loop_out),
    .tx_in(mii_tx_out), .link_clock_out(link_clock_in), .rx_out(mii_rx_in));
  // 50 ns system clock
  always #25 clock_in = ~clock_in;
  // Next pseudo-random word
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Reference receive decision for the perfect-filter cases used here
  function automatic logic dlv(input emm_pkg::emm_mode_type m,
    input logic [47:0] d);
    if (!m.receiver_on) return 1'b0;
    if (m.receive_everything || m.accept_any_frame) return 1'b1;
    if (&d) return !m.drop_broadcast;
    return d == station_addr_in;
  endfunction
  // Verdict and end of run
  task automatic results;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] s, input logic [63:0] x);
    checks++;
    if (s !== x) begin
      fail_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  // One AHB-Lite single word transfer; waits are bounded
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int k;
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= a;
    hwrite_in <= w;
    hsize_in <= emm_pkg::HSIZE_WORD;
    k = 0;
    do begin
      @(posedge clock_in);
      k++;
    end while (hreadyout_out !== 1'b1 && k < 50);
    htrans_in <= 2'h0;
    hsel_in <= 1'b0;
    hwdata_in <= d;
    do begin
      @(posedge clock_in);
      k++;
    end while (hreadyout_out !== 1'b1 && k < 99);
    r = hrdata_out;
    if (k >= 99) begin fail_count++; results; end
  endtask
  initial begin
    repeat (2) @(posedge clock_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    bus(0, emm_pkg::MODE_ADDR, 0, q);
    chk(q, emm_pkg::MODE_RESET);
    bus(1, emm_pkg::MODE_ADDR, '1, q);
    bus(0, emm_pkg::MODE_ADDR, 0, q);
    chk(q, emm_pkg::MODE_WRITE_MASK);
    bus(0, emm_pkg::MODE_ADDR + 32'h100, 0, q);
    chk(q, 0);
    // Frame decisions across the filter cases
    for (int i = 0; i < 7; i++) begin
      rnd = nxt(rnd);
      station_addr_in <= {rnd[15:0], rnd} & ~48'h0100_0000_0000;
      dst = kd[i] == 2 ? '1 : {rnd[15:0], rnd} & ~48'h0100_0000_0000;
      if (kd[i] == 0) dst = {rnd, rnd[15:0]} & ~48'h0100_0000_0000;
      bus(1, emm_pkg::MODE_ADDR, md[i], q);
      rx_info_in <= {dst, rnd[5:0], 1'b0, (i % 2) ? 16'h002E : 16'h002D};
      rx_frame_end_in <= 1'b1;
      @(posedge clock_in);
      rx_frame_end_in <= 1'b0;
      @(posedge clock_in);
      e = dlv(md[i], dst);
      chk(rx_deliver_out, e);
      chk(rx_strip_out, e && md[i].auto_pad_strip && !(i % 2));
    end
    // Byte order and port routing, both settings of each
    for (int j = 0; j < 2; j++) begin
      bus(1, emm_pkg::MODE_ADDR, j ? 32'h48000008 : 32'h8, q);
      rnd = nxt(rnd);
      buf_word_in <= rnd;
      core_tx_in <= {1'b1, rnd[3:0]};
      repeat (3) @(posedge clock_in);
      chk(buf_word_out, j ? {rnd[7:0], rnd[15:8], rnd[23:16], rnd[31:24]}
        : rnd);
      chk(j ? serial_tx_out : mii_tx_out, {1'b1, rnd[3:0]});
      chk(j ? mii_tx_out.en : serial_tx_out.en, 0);
      core_tx_in <= '0;
    end
    // Loopback: internal turns frames round, external goes via the PHY
    for (int m = 0; m < 2; m++) begin
      bus(1, emm_pkg::MODE_ADDR, m ? 32'h0050000C : 32'h0020000C, q);
      rnd = nxt(rnd);
      core_tx_in <= {1'b1, rnd[3:0]};
      sqe_missing_in <= 1'b1;
      repeat (4) @(posedge clock_in);
      chk({external_loop_out, mii_tx_out.en}, {m[0], m[0]});
      chk(core_rx_out, {1'b1, rnd[3:0]});
      chk({sqe_check_on_out, heartbeat_fail_out}, {2{!m[0]}});
      core_tx_in <= '0;
      sqe_missing_in <= 1'b0;
    end
    // Transmit request held while the transmitter is off, then on
    bus(1, emm_pkg::MODE_ADDR, 0, q);
    tx_request_in <= 1'b1;
    n = 0;
    repeat (20) begin @(posedge clock_in); n += int'(tx_go_out === 1'b1); end
    chk(n, 0);
    bus(1, emm_pkg::MODE_ADDR, 32'h8, q);
    n = 0;
    while (tx_go_out !== 1'b1 && n < 20) begin @(posedge clock_in); n++; end
    chk(tx_go_out, 1);
    tx_request_in <= 1'b0;
    tx_done_in <= 1'b1;
    @(posedge clock_in);
    tx_done_in <= 1'b0;
    // Collision: single attempt ends with retry error, late one is dropped
    for (int c = 0; c < 2; c++) begin
      bus(1, emm_pkg::MODE_ADDR, c ? 32'h8 : 32'h408, q);
      tx_request_in <= 1'b1;
      n = 0;
      while (tx_go_out !== 1'b1 && n < 20) begin
        @(posedge clock_in);
        n++;
      end
      tx_request_in <= 1'b0;
      collision_in <= 1'b1;
      late_collision_in <= c[0];
      @(posedge clock_in);
      collision_in <= 1'b0;
      late_collision_in <= 1'b0;
      @(posedge clock_in);
      chk({tx_drop_out, late_collision_out}, {1'b1, c[0]});
      chk(retry_error_out, !c[0]);
    end
    // Reset in mid-run brings the control word back to its reset value
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    bus(0, emm_pkg::MODE_ADDR, 0, q);
    chk(q, emm_pkg::MODE_RESET);
    results;
  end
endmodule // emm_mode_control_tb
`default_nettype wire
